/* boot_consts.vh */
// What this block does
// - in single-boot mode the interpreter starts at reset and knows four commands
// - first host byte 0x86 picks uart mode, 0x30 picks clocked mode
// - uart rate not achievable: abort, stay silent on the link forever
// - answer mode byte with 0x86 (uart, rate ok) or 0x30 (clocked)
// - mode detection samples the receive pin as a plain port level
// - receiver stays off (receiver_on=0) while the first byte is handled
// - clocked mode takes the shift clock from the host as input
// - clocked mode ignores receive errors, never answers with bit 3 error
// - erase command 0x40 answered 0x40, invalid 0xX1, receive error 0xX8
// - erase confirmation 0x54 in fifth byte is answered 0x40
// - seventh byte reports erase outcome: 0x4F success, 0x4C failure
// - after the erase result, wait for a new command byte
// - any negative acknowledge returns to the command wait state
// - chip erase clears all blocks and protection, even protected ones
// - finished chip erase sets the flash security flag to 1
// - chip erase needs no password check
// - ram transfer checks host password against flash copy first
// - downloaded data only from 0x2000_0400 up, then jump to load address
// - flash sum returns the sum of all flash, never raw contents
// - product info returns name, memory setup and bytes 0x3F83_FFF0..3
// - negative acknowledges carry the previous command's upper nibble
// - ram transfer command is 0x10 and is echoed as 0x10
`ifndef BOOT_CONSTS_VH
`define BOOT_CONSTS_VH
`define MODE_UART      8'h86
`define MODE_CLOCKED   8'h30
`define CMD_RAM_XFER   8'h10
`define CMD_FLASH_SUM  8'h20
`define CMD_PROD_INFO  8'h30
`define CMD_ERASE      8'h40
`define ERASE_CONFIRM  8'h54
`define ACK_ERASE_OK   8'h4F
`define ACK_ERASE_FAIL 8'h4C
`define NAK_INVALID    4'h1
`define NAK_RX_ERROR   4'h8
`define RAM_LOW_ADDR   32'h2000_0400
`define INFO_ADDR_LO   32'h3F83_FFF0
`define INFO_ADDR_HI   32'h3F83_FFF3
`define PASS_ADDR_LO   32'h3F83_FFF4
`define PASS_BYTES     12
`define CLK_MHZ        200
`define MAX_DIV        16'hFFFF
`endif

/* serial_byte_engine.v */
`timescale 1ns/1ps
`include "boot_consts.vh"
// byte serialiser for both link modes; uart uses a baud enable from a
// divider, clocked mode shifts on edges of the synchronised host clock
module serial_byte_engine (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        clocked_mode,
    input  wire        receiver_on,
    input  wire [15:0] bit_div,
    input  wire        rx_pin,
    input  wire        sclk_rise,
    input  wire        sclk_fall,
    input  wire        tx_start,
    input  wire [7:0]  tx_byte,
    output reg         tx_pin,
    output wire        tx_busy,
    output reg         rx_valid,
    output reg  [7:0]  rx_byte,
    output reg         rx_error
);
    reg [15:0] bcnt_r;
    reg [3:0]  tbit_r;
    reg [9:0]  tsh_r;
    reg        tact_r;
    reg [15:0] rcnt_r;
    reg [3:0]  rbit_r;
    reg [8:0]  rsh_r;
    reg        ract_r;
    wire       tick = (bcnt_r == 16'h0000);

    assign tx_busy = tact_r;

    // =========================================
    // baud divider
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) bcnt_r <= 16'h0000;
        else if (tick || !tact_r) bcnt_r <= bit_div;
        else bcnt_r <= bcnt_r - 16'h0001;
    end

    // =========================================
    // transmit
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tact_r <= 1'b0;
            tbit_r <= 4'h0;
            tsh_r  <= 10'h3FF;
            tx_pin <= 1'b1;
        end else if (tx_start && !tact_r) begin
            tact_r <= 1'b1;
            tbit_r <= clocked_mode ? 4'h8 : 4'hA;
            tsh_r  <= clocked_mode ? {2'b11, tx_byte} : {1'b1, tx_byte, 1'b0};
            tx_pin <= clocked_mode ? tx_byte[0] : 1'b1;
        end else if (tact_r && ((clocked_mode && sclk_rise) || (!clocked_mode && tick))) begin
            // clocked: data changes after the sampling edge, lsb first
            tx_pin <= clocked_mode ? tsh_r[1] : tsh_r[0];
            tsh_r  <= {1'b1, tsh_r[9:1]};
            tbit_r <= tbit_r - 4'h1;
            if (tbit_r == 4'h1) tact_r <= 1'b0;
        end
    end

    // =========================================
    // receive; half-bit start check catches glitches
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ract_r   <= 1'b0;
            rcnt_r   <= 16'h0000;
            rbit_r   <= 4'h0;
            rsh_r    <= 9'h000;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
            rx_error <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!receiver_on) begin
                ract_r <= 1'b0;
                rbit_r <= 4'h0;
            end else if (clocked_mode) begin
                if (sclk_rise) begin
                    rsh_r <= {rx_pin, rsh_r[8:1]};
                    rbit_r <= (rbit_r == 4'h7) ? 4'h0 : rbit_r + 4'h1;
                    if (rbit_r == 4'h7) begin
                        rx_valid <= 1'b1;
                        rx_byte  <= {rx_pin, rsh_r[8:2]};
                        rx_error <= 1'b0;
                    end
                end
            end else if (!ract_r) begin
                if (!rx_pin) begin
                    ract_r <= 1'b1;
                    rcnt_r <= {1'b0, bit_div[15:1]};
                    rbit_r <= 4'h0;
                end
            end else if (rcnt_r != 16'h0000) begin
                rcnt_r <= rcnt_r - 16'h0001;
            end else begin
                rcnt_r <= bit_div;
                rsh_r  <= {rx_pin, rsh_r[8:1]};
                rbit_r <= rbit_r + 4'h1;
                if (rbit_r == 4'h0 && rx_pin) ract_r <= 1'b0;
                if (rbit_r == 4'h9) begin
                    ract_r   <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_byte  <= rsh_r[8:1];
                    rx_error <= !rx_pin;
                end
            end
        end
    end
endmodule // serial_byte_engine

/* boot_command_interpreter.v */
`timescale 1ns/1ps
`include "boot_consts.vh"
module boot_command_interpreter #(
    parameter ERASE_CYCLES = 32'd8192,
    parameter MIN_DIV      = 16'd4
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        single_boot,
    input  wire        rx_pin,
    input  wire        sclk_pin,
    output wire        tx_pin,
    output reg         receiver_on,
    output reg         sclk_input_mode,
    output reg         clocked_mode,
    output reg         boot_aborted,
    output reg         erase_start,
    input  wire        erase_done,
    input  wire        erase_ok,
    output reg         flash_security_flag,
    output reg         cmd_ram_xfer,
    output reg         cmd_flash_sum,
    output reg         cmd_prod_info,
    output reg  [7:0]  last_cmd
);
    localparam S_IDLE    = 4'd0;
    localparam S_MODE    = 4'd1;
    localparam S_MODEACK = 4'd2;
    localparam S_CMD     = 4'd3;
    localparam S_ACK     = 4'd4;
    localparam S_CONF    = 4'd5;
    localparam S_ERASE   = 4'd6;
    localparam S_RESULT  = 4'd7;
    localparam S_HANDOFF = 4'd8;
    localparam S_DEAD    = 4'd9;

    reg [3:0]  state_r;
    reg [1:0]  rxs_r;
    reg [1:0]  scs_r;
    reg        sc_d_r;
    reg        rx_d_r;
    reg [15:0] mcnt_r;
    reg [15:0] low_r;
    reg [15:0] bit_div_r;
    reg [7:0]  ack_r;
    reg        ack_go_r;
    reg [3:0]  ack_next_r;
    reg [2:0]  handoff_r;
    wire       rx_sync = rxs_r[1];
    wire       sclk_rise = scs_r[1] & ~sc_d_r;
    wire       sclk_fall = ~scs_r[1] & sc_d_r;
    wire       tx_busy;
    wire       rx_valid;
    wire [7:0] rx_byte;
    wire       rx_error;

    function [7:0] nak;
        input [7:0] prev;
        input [3:0] code;
        nak = {prev[7:4], code};
    endfunction

    // =========================================
    // input synchronisers
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rxs_r  <= 2'b11;
            scs_r  <= 2'b11;
            sc_d_r <= 1'b1;
            rx_d_r <= 1'b1;
        end else begin
            rxs_r  <= {rxs_r[0], rx_pin};
            scs_r  <= {scs_r[0], sclk_pin};
            sc_d_r <= scs_r[1];
            rx_d_r <= rx_sync;
        end
    end

    serial_byte_engine u_engine (
        .mclk         (mclk),
        .resetn       (resetn),
        .clocked_mode (clocked_mode),
        .receiver_on  (receiver_on),
        .bit_div      (bit_div_r),
        .rx_pin       (rx_sync),
        .sclk_rise    (sclk_rise),
        .sclk_fall    (sclk_fall),
        .tx_start     (ack_go_r),
        .tx_byte      (ack_r),
        .tx_pin       (tx_pin),
        .tx_busy      (tx_busy),
        .rx_valid     (rx_valid),
        .rx_byte      (rx_byte),
        .rx_error     (rx_error)
    );

    // =========================================
    // command sequencer
    // the mode byte is timed from the pin level: in uart the first low run
    // (start bit plus the 0x86 low bit 0) lasts two bit times, halved to one bit time;
    // in clocked mode the host clock toggling picks the mode
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r             <= S_IDLE;
            receiver_on         <= 1'b0;
            sclk_input_mode     <= 1'b0;
            clocked_mode        <= 1'b0;
            boot_aborted        <= 1'b0;
            erase_start         <= 1'b0;
            flash_security_flag <= 1'b0;
            cmd_ram_xfer        <= 1'b0;
            cmd_flash_sum       <= 1'b0;
            cmd_prod_info       <= 1'b0;
            last_cmd            <= 8'h00;
            mcnt_r              <= 16'h0000;
            low_r               <= 16'h0000;
            bit_div_r           <= 16'h0000;
            ack_r               <= 8'h00;
            ack_go_r            <= 1'b0;
            ack_next_r          <= S_CMD;
            handoff_r           <= 3'd0;
        end else begin
            erase_start   <= 1'b0;
            cmd_ram_xfer  <= 1'b0;
            cmd_flash_sum <= 1'b0;
            cmd_prod_info <= 1'b0;
            ack_go_r      <= 1'b0;
            case (state_r)
            S_IDLE: begin
                receiver_on <= 1'b0;
                if (single_boot) state_r <= S_MODE;
            end
            S_MODE: begin
                // receive pin watched as a port level, receiver kept off
                receiver_on <= 1'b0;
                if (sclk_fall) begin
                    clocked_mode    <= 1'b1;
                    sclk_input_mode <= 1'b1;
                    mcnt_r          <= 16'h0000;
                    state_r         <= S_MODEACK;
                end else if (!rx_sync) begin
                    if (low_r != `MAX_DIV) low_r <= low_r + 16'h0001;
                end else if (rx_d_r == 1'b0) begin
                    // low run ended: start bit then 0x86 lsb first 0,1,1 so low = 2 bits
                    if (low_r[15:1] < MIN_DIV) begin
                        boot_aborted <= 1'b1;
                        state_r      <= S_DEAD;
                    end else begin
                        bit_div_r <= {1'b0, low_r[15:1]} - 16'h0001;
                        mcnt_r    <= 16'h0000;
                        state_r   <= S_MODEACK;
                    end
                end
            end
            S_MODEACK: begin
                // wait out the rest of the mode byte before the echo; in clocked
                // mode the echo must not shift on the mode byte's own clock rises
                if (clocked_mode ? (mcnt_r == 16'h0008) :
                    (mcnt_r == 16'hFFFF || (rx_sync && mcnt_r[15:0] >
                    {bit_div_r[13:0], 2'b00} + {bit_div_r[14:0], 1'b0}))) begin
                    ack_r       <= clocked_mode ? `MODE_CLOCKED : `MODE_UART;
                    ack_go_r    <= 1'b1;
                    receiver_on <= 1'b1;
                    ack_next_r  <= S_CMD;
                    state_r     <= S_ACK;
                end else if (clocked_mode) begin
                    if (sclk_rise) mcnt_r <= mcnt_r + 16'h0001;
                end else begin
                    mcnt_r <= rx_sync ? mcnt_r + 16'h0001 : 16'h0000;
                end
            end
            S_CMD: begin
                if (rx_valid) begin
                    if (rx_error && !clocked_mode) begin
                        ack_r      <= nak(last_cmd, `NAK_RX_ERROR);
                        ack_next_r <= S_CMD;
                    end else if (rx_byte == `CMD_ERASE) begin
                        ack_r      <= `CMD_ERASE;
                        last_cmd   <= rx_byte;
                        ack_next_r <= S_CONF;
                    end else if (rx_byte == `CMD_RAM_XFER || rx_byte == `CMD_FLASH_SUM ||
                                 rx_byte == `CMD_PROD_INFO) begin
                        ack_r      <= rx_byte;
                        last_cmd   <= rx_byte;
                        ack_next_r <= S_HANDOFF;
                        handoff_r  <= (rx_byte == `CMD_RAM_XFER) ? 3'd1 :
                                      (rx_byte == `CMD_FLASH_SUM) ? 3'd2 : 3'd4;
                    end else begin
                        ack_r      <= nak(last_cmd, `NAK_INVALID);
                        ack_next_r <= S_CMD;
                    end
                    ack_go_r <= 1'b1;
                    state_r  <= S_ACK;
                end
            end
            S_ACK: begin
                // hold until the engine has taken and finished the byte
                if (!ack_go_r && !tx_busy) state_r <= ack_next_r;
            end
            S_CONF: begin
                if (rx_valid) begin
                    if (rx_error && !clocked_mode) begin
                        ack_r      <= nak(last_cmd, `NAK_RX_ERROR);
                        ack_next_r <= S_CMD;
                    end else if (rx_byte == `ERASE_CONFIRM) begin
                        ack_r       <= `CMD_ERASE;
                        ack_next_r  <= S_ERASE;
                        erase_start <= 1'b1;
                    end else begin
                        ack_r      <= nak(last_cmd, `NAK_INVALID);
                        ack_next_r <= S_CMD;
                    end
                    ack_go_r <= 1'b1;
                    state_r  <= S_ACK;
                end
            end
            S_ERASE: begin
                if (erase_done) begin
                    flash_security_flag <= 1'b1;
                    ack_r      <= erase_ok ? `ACK_ERASE_OK : `ACK_ERASE_FAIL;
                    ack_go_r   <= 1'b1;
                    ack_next_r <= S_CMD;
                    state_r    <= S_ACK;
                end
            end
            S_HANDOFF: begin
                // password, sum and info routines live in the flash handler
                cmd_ram_xfer  <= handoff_r[0];
                cmd_flash_sum <= handoff_r[1];
                cmd_prod_info <= handoff_r[2];
                state_r       <= S_CMD;
            end
            S_DEAD: begin
                receiver_on  <= 1'b0;
                boot_aborted <= 1'b1;
            end
            default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // boot_command_interpreter

/* boot_interp_checker_sva.sv */
`timescale 1ns/1ps
// ==========================================
// port checker for the boot interpreter
module boot_interp_checker #(
    parameter ERASE_CYCLES = 32'd8192,
    parameter MIN_DIV      = 16'd4
) (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       tx_pin,
    input wire logic       receiver_on,
    input wire logic       sclk_input_mode,
    input wire logic       clocked_mode,
    input wire logic       boot_aborted,
    input wire logic       erase_start,
    input wire logic       erase_done,
    input wire logic       flash_security_flag,
    input wire logic       cmd_ram_xfer,
    input wire logic       cmd_flash_sum,
    input wire logic       cmd_prod_info,
    input wire logic [7:0] last_cmd
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_no_erase8;
        (!erase_start) [*8];
    endsequence
    property p_abort_silent;
        boot_aborted |-> tx_pin && !clocked_mode;
    endproperty
    property p_secure_set;
        erase_done |-> ##[0:3] flash_security_flag;
    endproperty
    property p_erase_once;
        erase_start |=> s_no_erase8;
    endproperty
    property p_one_cmd;
        $onehot0({cmd_ram_xfer, cmd_flash_sum, cmd_prod_info, erase_start});
    endproperty
    property p_ram_cmd;
        cmd_ram_xfer |-> last_cmd == 8'h10;
    endproperty
    property p_info_cmd;
        cmd_prod_info |-> last_cmd == 8'h30;
    endproperty
    property p_clk_input;
        clocked_mode |-> sclk_input_mode;
    endproperty
    // receiver comes on only before the echo start bit
    property p_rx_late;
        $rose(receiver_on) |-> tx_pin;
    endproperty
    a_abort_silent: assert property (p_abort_silent) else $error("link active after abort");
    a_secure_set: assert property (p_secure_set) else $error("security flag not set");
    a_erase_once: assert property (p_erase_once) else $error("erase start repeated");
    a_one_cmd: assert property (p_one_cmd) else $error("two command pulses");
    a_ram_cmd: assert property (p_ram_cmd) else $error("ram pulse on wrong code");
    a_info_cmd: assert property (p_info_cmd) else $error("info pulse on wrong code");
    a_clk_input: assert property (p_clk_input) else $error("shift clock not input");
    a_rx_late: assert property (p_rx_late) else $error("receiver on during echo");
endmodule // boot_interp_checker

/* host_link.sv */
`timescale 1ns/1ps
// ==========================================
// host controller on the boot link
module host_link (
    output logic      rx_pin,
    output logic      sclk_pin,
    input wire logic  tx_pin
);
    initial begin
        rx_pin = 1'b1;
        sclk_pin = 1'b1;
    end
    task automatic uart_send(input logic [7:0] b, input int bt);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin = f[i];
            #(bt);
        end
    endtask
    // bounded wait: a silent device leaves got low
    task automatic uart_recv(output logic [7:0] b, output logic got, input int bt);
        int t;
        b = 8'hXX;
        got = 1'b0;
        t = 0;
        while (tx_pin === 1'b1 && t < 6000) begin
            #1;
            t++;
        end
        if (t < 6000) begin
            got = 1'b1;
            #(bt + bt / 2);
            for (int i = 0; i < 8; i++) begin
                b[i] = tx_pin;
                #(bt);
            end
        end
    endtask
    // sclk rests high between frames, data shows the inverse of its last bit
    task automatic clk_xfer(input logic [7:0] o, output logic [7:0] d, input int h);
        for (int i = 0; i < 8; i++) begin
            rx_pin = o[i];
            d[i] = tx_pin;
            sclk_pin = 1'b0;
            #(h);
            sclk_pin = 1'b1;
            #(h);
        end
        rx_pin = ~o[7];
        #300;
    endtask
endmodule // host_link

/* tb_serial_boot_command_protocol.sv */
`timescale 1ns/1ps
// ==========================================
// bench: uart session, abort, clocked session
module tb_serial_boot_command_protocol;
    logic       mclk, resetn, single_boot, rx_pin, sclk_pin, tx_pin, got, ok_sel;
    logic       receiver_on, sclk_input_mode, clocked_mode, boot_aborted, erase_start;
    logic       erase_done, erase_ok, flash_security_flag, cmd_ram_xfer, cmd_flash_sum;
    logic       cmd_prod_info;
    logic [7:0] last_cmd, b, c;
    logic [3:0] seen;
    int         err_count, check_count, cycles, ecnt;
    integer     seed;
    always #2.5 mclk = ~mclk;
    boot_command_interpreter #(.ERASE_CYCLES(32'd200), .MIN_DIV(16'd4)) i_dut (
        .mclk(mclk), .resetn(resetn), .single_boot(single_boot), .rx_pin(rx_pin),
        .sclk_pin(sclk_pin), .tx_pin(tx_pin), .receiver_on(receiver_on),
        .sclk_input_mode(sclk_input_mode), .clocked_mode(clocked_mode),
        .boot_aborted(boot_aborted), .erase_start(erase_start), .erase_done(erase_done),
        .erase_ok(erase_ok), .flash_security_flag(flash_security_flag),
        .cmd_ram_xfer(cmd_ram_xfer), .cmd_flash_sum(cmd_flash_sum),
        .cmd_prod_info(cmd_prod_info), .last_cmd(last_cmd));
    host_link i_host (.rx_pin(rx_pin), .sclk_pin(sclk_pin), .tx_pin(tx_pin));
    // flash model: erase takes 200 cycles, outcome given with done
    always @(negedge mclk) begin
        erase_done <= 1'b0;
        if (erase_start) ecnt <= 200;
        else if (ecnt > 0) begin
            ecnt <= ecnt - 1;
            erase_done <= (ecnt == 1);
            erase_ok <= ok_sel;
        end
    end
    always @(posedge mclk) begin
        seen <= seen | {erase_start, cmd_prod_info, cmd_flash_sum, cmd_ram_xfer};
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic boot();
        resetn = 1'b0;
        single_boot = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        single_boot = 1'b1;
    endtask
    task automatic u_cmd(input logic [7:0] x, input logic [7:0] e, input logic [7:0] m);
        fork
            i_host.uart_send(x, 80);
            i_host.uart_recv(b, got, 80);
        join
        chk("uart ack", b & m, e & m);
    endtask
    task automatic c_read(input logic [7:0] e, input logic [7:0] m, input int h);
        i_host.clk_xfer(8'hFF, b, h);
        chk("clk ack", b & m, e & m);
    endtask
    task automatic c_cmd(input logic [7:0] x, input logic [7:0] e, input logic [7:0] m);
        i_host.clk_xfer(x, b, 32);
        c_read(e, m, 32);
    endtask
    initial begin
        seed = 32'h9db3;
        {mclk, erase_done, erase_ok, ok_sel, seen, cycles, ecnt} = '0;
        boot();
        fork
            u_cmd(8'h86, 8'h86, 8'hFF);
            #400 chk("rx on", {7'h0, receiver_on}, 8'h00);
        join
        chk("rx on", {7'h0, receiver_on}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            c = 8'h50 + 8'($unsigned($random(seed)) % 176);
            u_cmd(c, 8'h01, 8'h0F);
        end
        u_cmd(8'h20, 8'h20, 8'hFF);
        u_cmd(8'h30, 8'h30, 8'hFF);
        repeat (40) @(negedge mclk);
        chk("pulses", {4'h0, seen}, 8'h06);
        ok_sel = 1'($random(seed));
        for (int e = 0; e < 2; e++) begin
            seen = 4'h0;
            u_cmd(8'h40, 8'h40, 8'hFF);
            u_cmd(8'h54, 8'h40, 8'hFF);
            i_host.uart_recv(b, got, 80);
            chk("erase result", b, ok_sel ? 8'h4F : 8'h4C);
            chk("erase pulse", {4'h0, seen}, 8'h08);
            chk("secure", {7'h0, flash_security_flag}, 8'h01);
            ok_sel = ~ok_sel;
        end
        u_cmd(8'h40, 8'h40, 8'hFF);
        u_cmd(8'h55, 8'h41, 8'hFF);
        seen = 4'h0;
        u_cmd(8'h10, 8'h10, 8'hFF);
        repeat (40) @(negedge mclk);
        chk("ram pulse", {4'h0, seen}, 8'h01);
        boot();
        fork
            i_host.uart_send(8'h86, 10);
            i_host.uart_recv(b, got, 10);
        join
        chk("abort echo", {7'h0, got}, 8'h00);
        chk("aborted", {7'h0, boot_aborted}, 8'h01);
        boot();
        i_host.clk_xfer(8'h30, b, 512);
        c_read(8'h30, 8'hFF, 512);
        chk("clocked", {6'h0, clocked_mode, sclk_input_mode}, 8'h03);
        c_cmd(8'h40, 8'h40, 8'hFF);
        c_cmd(8'h54, 8'h40, 8'hFF);
        repeat (300) @(negedge mclk);
        c_read(ok_sel ? 8'h4F : 8'h4C, 8'hFF, 32);
        c_cmd(8'h77, 8'h41, 8'hFF);
        end_of_test();
    end
endmodule // tb_serial_boot_command_protocol
bind boot_command_interpreter boot_interp_checker #(
    .ERASE_CYCLES(ERASE_CYCLES), .MIN_DIV(MIN_DIV)) i_chk (
    .mclk(mclk), .resetn(resetn), .tx_pin(tx_pin), .receiver_on(receiver_on),
    .sclk_input_mode(sclk_input_mode), .clocked_mode(clocked_mode),
    .boot_aborted(boot_aborted), .erase_start(erase_start), .erase_done(erase_done),
    .flash_security_flag(flash_security_flag), .cmd_ram_xfer(cmd_ram_xfer),
    .cmd_flash_sum(cmd_flash_sum), .cmd_prod_info(cmd_prod_info), .last_cmd(last_cmd));
